// ### bench/bsr_node_model.sv
`timescale 1ns/100ps
`default_nettype none
// Bus node on one segment: sends 16 slots of line levels
module bsr_node_model
  import bsr_pkg::*;
#(
  parameter int P_HALF = 33 // Cycles per slot
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_go,
  input  wire logic [15:0] i_pat,
  input  wire logic        i_glitch,
  input  wire logic        i_stream,
  output var  logic        o_line,
  output var  logic        o_busy
);
  logic [15:0] pat_reg;         // Levels being sent
  logic [3:0]  slot_reg = 4'h0; // Current slot
  bsr_cnt_t    cnt_reg = 16'h0; // Cycles into slot
  logic        busy_reg = 1'b0; // Frame on the wire
  logic        glitch;          // Short out-of-place pulse
  // Three-cycle inversion at slot 8 start, far below legal spacing
  assign glitch = i_glitch && (slot_reg == 4'h8) && (cnt_reg < 16'h0003);
  // Released line sits at its idle level, never at the last bit
  assign o_line = busy_reg & (pat_reg[slot_reg] ^ glitch);
  assign o_busy = busy_reg;
  // Slot sequencer; streaming wraps to jabber the segment
  always_ff @(posedge i_sys_clk)
  begin
    if (i_go)
    begin
      busy_reg <= 1'b1;
      slot_reg <= 4'h0;
      cnt_reg  <= 16'h0;
      pat_reg  <= i_pat;
    end
    else if (busy_reg && cnt_reg == bsr_cnt_t'(P_HALF - 1))
    begin
      cnt_reg  <= 16'h0;
      slot_reg <= slot_reg + 4'h1;
      if (slot_reg == 4'hF && !i_stream)
        busy_reg <= 1'b0;
    end
    else if (busy_reg)
      cnt_reg <= cnt_reg + 16'h1;
  end
endmodule // bsr_node_model
`default_nettype wire

// ### bench/tb_bsr_repeater_top.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench: node models on both segments
module tb_bsr_repeater_top
  import bsr_pkg::*;
;
  localparam int P_HALF = 33;   // Slot length in cycles
  localparam int P_JAB  = 2000; // Shortened jabber limit
  typedef struct {logic seg; logic [15:0] pat; int gap; int lat;} bsr_row_s;
  logic        sys_clk = 1'b0; // 100 MHz clock
  logic        sys_rst = 1'b1; // Sync reset
  logic [1:0]  go = 2'b00;     // Frame launch per segment
  logic [1:0]  glit = 2'b00;   // Inject out-of-place edge
  logic [1:0]  strm = 2'b00;   // Keep transmitter running
  logic [15:0] pat = 16'h0;    // Shared frame pattern
  logic [1:0]  line;           // Segment levels
  logic [1:0]  busy;           // Node activity
  logic [1:0]  tx [2];         // Driven levels per segment
  logic [1:0]  oe [2];         // Drive enables per segment
  logic [1:0]  coll;           // Collision flags
  logic [1:0]  jab;            // Jabber cut flags
  int          cyc = 0;        // Cycle count
  int          bad_count = 0;  // Mismatches
  int          n_compared = 0; // Comparisons
  int          t0;             // Launch cycle
  int          tend;           // Input end of last frame
  // Gaps kept well clear of the 2 and 4 us boundaries
  bsr_row_s rows [6] = '{
    '{1'b0, 16'hA5A5, 500, 100},
    '{1'b1, 16'hB3CD, 500, 100},
    '{1'b1, 16'hF00F, 300, 300},
    '{1'b0, 16'h9669, 500, 100},
    '{1'b0, 16'h8E71, 250, 300},
    '{1'b1, 16'hDA57, 450, 100}};
  // Both lines mirrored so each half is checked
  bsr_node_model #(.P_HALF(P_HALF)) u_bsr_node_model_1 (.i_sys_clk(sys_clk), .i_go(go[0]), .i_pat(pat),
    .i_glitch(glit[0]), .i_stream(strm[0]), .o_line(line[0]), .o_busy(busy[0]));
  bsr_node_model #(.P_HALF(P_HALF)) u_bsr_node_model_2 (.i_sys_clk(sys_clk), .i_go(go[1]), .i_pat(pat),
    .i_glitch(glit[1]), .i_stream(strm[1]), .o_line(line[1]), .o_busy(busy[1]));
  bsr_repeater_top #(.P_JABBER_CYC(P_JAB)) u_bsr_repeater_top (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
    .i_seg1_rx({2{line[0]}}), .i_seg2_rx({2{line[1]}}), .o_seg1_tx(tx[0]), .o_seg1_oe(oe[0]),
    .o_seg2_tx(tx[1]), .o_seg2_oe(oe[1]), .o_collision(coll), .o_jabber_cut(jab));
  // Clock
  always #5 sys_clk = ~sys_clk;
  // Cycle count and hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 30000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  // Verdict and end of run
  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Two-bit compare
  task automatic cmp2(input logic [1:0] got, input logic [1:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  // Wait for a cycle, sampling at the falling edge
  task automatic wait_to(input int t);
    while (cyc < t)
      @(negedge sys_clk);
  endtask
  // One-cycle launch pulse on a segment
  task automatic launch(input int s, input logic [15:0] p, output int ts);
    pat = p;
    go[s] = 1'b1;
    ts = cyc;
    @(negedge sys_clk);
    go[s] = 1'b0;
  endtask
  // Mid-slot check of the far segment from slot j0 on
  task automatic chk(input int s, input logic [15:0] p, input int lat, input int ts, input int j0);
    // Driven but still idle while the delayed start is on its way
    if (j0 == 0)
    begin
      wait_to(ts + 30);
      cmp2(tx[1 - s], 2'b00, "idle before delayed start");
    end
    for (int j = j0; j < 16; j++)
    begin
      wait_to(ts + lat + j * P_HALF + P_HALF / 2 + 1);
      cmp2(tx[1 - s], {2{p[j]}}, "forwarded level");
      cmp2(oe[1 - s], 2'b11, "drive enable");
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(negedge sys_clk);
    cmp2(tx[0] | tx[1] | oe[0] | oe[1] | coll | jab, 2'b00, "reset outputs");
    sys_rst = 1'b0;
    tend = cyc;
    foreach (rows[i])
    begin
      wait_to(tend + rows[i].gap);
      launch(int'(rows[i].seg), rows[i].pat, t0);
      tend = t0 + 16 * P_HALF;
      fork
        automatic bsr_row_s r = rows[i];
        automatic int ts = t0;
        chk(int'(r.seg), r.pat, r.lat, ts, 0);
      join_none
    end
    // Other segment starts mid-frame: ignored, first frame intact
    // No run of equal slots long enough to read as quiet input
    wait_to(tend + 700);
    launch(0, 16'hA5A5, t0);
    fork
      automatic int ts = t0;
      chk(0, 16'hA5A5, 100, ts, 0);
    join_none
    wait_to(t0 + 100);
    launch(1, 16'h5555, tend);
    for (int k = 0; k < 4; k++)
    begin
      wait_to(t0 + 150 + k * 150);
      cmp2(oe[0], 2'b00, "output side not driven");
    end
    wait_to(t0 + 530 + 195);
    cmp2(oe[1], 2'b11, "direction held");
    wait_to(t0 + 530 + 210);
    cmp2(oe[1], 2'b00, "released after quiet");
    // Out-of-place edge: collision then raw passthrough
    wait_to(t0 + 1400);
    glit[1] = 1'b1;
    launch(1, 16'hC3C5, t0);
    wait_to(t0 + 120);
    cmp2(coll, 2'b00, "no early collision");
    wait_to(t0 + 12 * P_HALF);
    cmp2(coll, 2'b11, "collision flagged");
    chk(1, 16'hC3C5, 1, t0, 12);
    glit[1] = 1'b0;
    // Jabbering transmitter cut, next master frame forwarded
    wait_to(t0 + 1200);
    strm[0] = 1'b1;
    launch(0, 16'h5555, t0);
    wait_to(t0 + P_JAB - 200);
    cmp2(jab | ~oe[1], 2'b00, "forwarding before limit");
    wait_to(t0 + P_JAB + 300);
    cmp2(jab, 2'b11, "jabber cut");
    cmp2(oe[1], 2'b00, "cut drive");
    strm[0] = 1'b0;
    wait_to(t0 + P_JAB + 1500);
    launch(0, 16'h9669, t0);
    wait_to(t0 + 100);
    cmp2(jab, 2'b00, "cut cleared on claim");
    chk(0, 16'h9669, 100, t0, 0);
    wait_to(t0 + 16 * P_HALF + 400);
    cmp2(oe[0] | oe[1], 2'b00, "idle drives neither");
    // Reset in mid-frame: every output back to idle
    launch(1, 16'hA5A5, t0);
    wait_to(t0 + 150);
    cmp2(oe[0], 2'b11, "driving before reset");
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp2(tx[0] | tx[1] | oe[0] | oe[1] | coll | jab, 2'b00, "reset mid-frame");
    sys_rst = 1'b0;
    end_of_test();
  end
endmodule // tb_bsr_repeater_top
`default_nettype wire

// ### hw/bsr_delay_line.sv
`timescale 1ns/100ps
`default_nettype none
// Re-timing shift lines for both segments of one line
module bsr_delay_line
  import bsr_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  bsr_dly_if.line   dly
);

  // History of each segment, newest sample in bit 0
  logic [LONG_TAP_LEN-1:0] seg1_reg;
  logic [LONG_TAP_LEN-1:0] seg1_next;
  logic [LONG_TAP_LEN-1:0] seg2_reg;
  logic [LONG_TAP_LEN-1:0] seg2_next;

  // Shift both histories every cycle
  always_comb
  begin
    seg1_next = {seg1_reg[LONG_TAP_LEN-2:0], dly.din[0]};
    seg2_next = {seg2_reg[LONG_TAP_LEN-2:0], dly.din[1]};
  end

  // Idle level after reset, so nothing spurious leaves the taps
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      seg1_reg <= '0;
      seg2_reg <= '0;
    end
    else
    begin
      seg1_reg <= seg1_next;
      seg2_reg <= seg2_next;
    end
  end

  // Taps come straight from flops
  assign dly.tap_short = {seg2_reg[SHORT_TAP_LEN-1], seg1_reg[SHORT_TAP_LEN-1]};
  assign dly.tap_long  = {seg2_reg[LONG_TAP_LEN-1], seg1_reg[LONG_TAP_LEN-1]};

endmodule // bsr_delay_line
`default_nettype wire

// ### hw/bsr_dly_if.sv
`timescale 1ns/100ps
`default_nettype none
// Raw segment samples in, delayed copies out; bit 0 segment 1, bit 1 segment 2
interface bsr_dly_if;
  logic [1:0] din;       // Raw levels from both segments
  logic [1:0] tap_short; // Normal-latency copy
  logic [1:0] tap_long;  // Postponed copy
  modport feed (output din, input tap_short, input tap_long);
  modport line (input din, output tap_short, output tap_long);
endinterface
`default_nettype wire

// ### hw/bsr_pkg.sv
`default_nettype none
package bsr_pkg;

  // Counter type shared by all timers
  typedef logic [15:0] bsr_cnt_t;

  // Per-line forwarding states
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_FWD, ST_CUT} bsr_state_e;

  // Clock period and printed times, all in ns
  localparam int CLK_NS         = 10;
  localparam int LATENCY_MAX_NS = 3000;
  localparam int FWD_NS         = 1000;
  localparam int QUIET_NS       = 2000;
  localparam int GAP_LONG_NS    = 4000;
  localparam int EDGE_TOL_NS    = 125;
  localparam int HALF_BIT_NS    = 333;
  localparam int JABBER_NS      = 228700;

  // Delay line taps; total pin-to-pin latency is tap plus one cycle
  localparam int LONG_TAP_LEN   = LATENCY_MAX_NS / CLK_NS - 1;
  localparam int SHORT_TAP_LEN  = FWD_NS / CLK_NS - 1;

  // Derived cycle counts: all round up except the half bit and the start hold, which round down
  localparam bsr_cnt_t QUIET_CYC      = bsr_cnt_t'((QUIET_NS + CLK_NS - 1) / CLK_NS);
  localparam bsr_cnt_t GAP_LONG_CYC   = bsr_cnt_t'((GAP_LONG_NS + CLK_NS - 1) / CLK_NS);
  localparam bsr_cnt_t TOL_CYC        = bsr_cnt_t'((EDGE_TOL_NS + CLK_NS - 1) / CLK_NS);
  localparam bsr_cnt_t HALF_BIT_CYC   = bsr_cnt_t'(HALF_BIT_NS / CLK_NS);
  localparam bsr_cnt_t MIN_SPACE_CYC  = bsr_cnt_t'(HALF_BIT_CYC - 2 * TOL_CYC);
  localparam bsr_cnt_t START_HOLD_CYC = bsr_cnt_t'(HALF_BIT_CYC / 2);
  localparam bsr_cnt_t SHORT_DRAIN    = bsr_cnt_t'(SHORT_TAP_LEN + 2);
  localparam bsr_cnt_t LONG_DRAIN     = bsr_cnt_t'(LONG_TAP_LEN + 2);
  // Frame age at which its start reaches each tap; before it the tap still holds older traffic
  localparam bsr_cnt_t SHORT_FILL     = bsr_cnt_t'(SHORT_TAP_LEN - 1);
  localparam bsr_cnt_t LONG_FILL      = bsr_cnt_t'(LONG_TAP_LEN - 1);
  localparam int       JABBER_CYC     = (JABBER_NS + CLK_NS - 1) / CLK_NS;
  localparam bsr_cnt_t CNT_MAX        = 16'hFFFF;
  localparam bsr_cnt_t CNT_ZERO       = 16'h0000;

  // Saturating increment used by every repeater timer
  function automatic bsr_cnt_t sat_inc(input bsr_cnt_t v);
    return (v == CNT_MAX) ? v : v + 16'h0001;
  endfunction

endpackage
`default_nettype wire

// ### hw/bsr_repeater_top.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - First starting segment becomes input direction
// - Forwarded frames re-timed, bits unchanged
// - Input to output latency at most 3 us
// - Keep direction until input quiet 2 us
// - Reverse direction after 2 us quiet, 3.01 us after a postponed frame
// - Frame in progress finishes fully
// - Accept edge displacement below 0.125 us
// - Marginal starts may be rejected
// - Illegal transition: collision, raw passthrough
// - Gap 2 to 4 us postpones output
// - Gap over 4 us adds no delay
// - Gaps under 2 us not guaranteed
// - Gap counted from last edge
// - Two independent halves, one per line
// - Cut transmitter active beyond 228.7 us
module bsr_repeater_top
  import bsr_pkg::*;
#(
  parameter int P_JABBER_CYC = JABBER_CYC // Jabber limit in cycles
)
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [1:0] i_seg1_rx,
  input  wire logic [1:0] i_seg2_rx,
  output var  logic [1:0] o_seg1_tx,
  output var  logic [1:0] o_seg1_oe,
  output var  logic [1:0] o_seg2_tx,
  output var  logic [1:0] o_seg2_oe,
  output var  logic [1:0] o_collision,
  output var  logic [1:0] o_jabber_cut
);

  // Jabber limit at counter width; saturation keeps it reachable
  localparam bsr_cnt_t JAB_LIM = bsr_cnt_t'(P_JABBER_CYC);

  for (genvar g = 0; g < 2; g++)
  begin : g_line
    bsr_state_e state_reg;   // Forwarding state
    bsr_state_e state_next;
    logic       dir_reg;     // 0: segment 1 to 2, 1: segment 2 to 1
    logic       dir_next;
    logic       long_reg;    // Postponed tap in use
    logic       long_next;
    logic       coll_reg;    // Collision seen in this frame
    logic       coll_next;
    logic       jab_reg;     // Frame cut for jabber
    logic       jab_next;
    bsr_cnt_t   quiet_reg;   // Cycles since last input edge
    bsr_cnt_t   quiet_next;
    bsr_cnt_t   act_reg;     // Cycles since frame start
    bsr_cnt_t   act_next;
    bsr_cnt_t   gap_reg;     // Cycles since last edge of previous frame
    bsr_cnt_t   gap_next;
    logic       rx1_reg;     // Previous sample, segment 1
    logic       rx1_next;
    logic       rx2_reg;     // Previous sample, segment 2
    logic       rx2_next;
    logic       tx1_reg;
    logic       tx1_next;
    logic       oe1_reg;
    logic       oe1_next;
    logic       tx2_reg;
    logic       tx2_next;
    logic       oe2_reg;
    logic       oe2_next;
    logic       e1;          // Transition on segment 1
    logic       e2;          // Transition on segment 2
    logic       in_now;      // Level of the input segment
    logic       in_edge;     // Transition on the input segment
    logic       out_bit;     // Level to put on the output segment
    bsr_cnt_t   drain;       // Quiet time needed before turnaround

    bsr_dly_if dly_bus ();

    // Both segments always feed the history, so the claim check costs no data
    assign dly_bus.din = {i_seg2_rx[g], i_seg1_rx[g]};

    bsr_delay_line u_dly (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .dly       (dly_bus)
    );

    // Edge detection on both segments
    assign e1      = i_seg1_rx[g] ^ rx1_reg;
    assign e2      = i_seg2_rx[g] ^ rx2_reg;
    // output segment echo never reaches the state machine
    assign in_now  = dir_reg ? i_seg2_rx[g] : i_seg1_rx[g];
    assign in_edge = dir_reg ? e2 : e1;

    // Next-state and output computation
    always_comb
    begin
      state_next = state_reg;
      dir_next   = dir_reg;
      long_next  = long_reg;
      coll_next  = coll_reg;
      jab_next   = jab_reg;
      quiet_next = in_edge ? CNT_ZERO : sat_inc(quiet_reg);
      act_next   = act_reg;
      gap_next   = gap_reg;
      rx1_next   = i_seg1_rx[g];
      rx2_next   = i_seg2_rx[g];
      // regenerated copy from the chosen tap
      // raw level once a collision is seen
      // idle until the delayed start reaches the tap, so a close predecessor never replays
      out_bit    = coll_reg ? in_now
                 : (act_reg < (long_reg ? LONG_FILL : SHORT_FILL)) ? 1'b0
                 : (long_reg ? dly_bus.tap_long[dir_reg] : dly_bus.tap_short[dir_reg]);
      // wait until the delayed copy has fully left
      drain      = coll_reg ? QUIET_CYC : (long_reg ? LONG_DRAIN : SHORT_DRAIN);
      oe1_next   = (state_reg == ST_FWD) && dir_reg;
      oe2_next   = (state_reg == ST_FWD) && !dir_reg;
      tx1_next   = oe1_next & out_bit;
      tx2_next   = oe2_next & out_bit;
      unique case (state_reg)
        ST_IDLE:
        begin
          // Gap saturates at the long threshold
          gap_next = (gap_reg >= GAP_LONG_CYC) ? gap_reg : sat_inc(gap_reg);
          // first edge claims; segment 1 wins a tie
          // either segment may claim after quiet
          if (e1 || e2)
          begin
            dir_next   = ~e1;
            // close follower gets the long tap
            long_next  = (gap_reg < GAP_LONG_CYC);
            coll_next  = 1'b0;
            jab_next   = 1'b0;
            quiet_next = CNT_ZERO;
            act_next   = CNT_ZERO;
            state_next = ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          act_next = sat_inc(act_reg);
          // start bit too short is rejected
          if (in_edge)
          begin
            state_next = ST_IDLE;
          end
          else if (act_reg >= START_HOLD_CYC)
          begin
            state_next = ST_FWD;
          end
        end
        ST_FWD:
        begin
          act_next = sat_inc(act_reg);
          // spacing floor leaves room for tolerated displacement
          if (in_edge && (quiet_reg < MIN_SPACE_CYC))
          begin
            coll_next = 1'b1;
          end
          if (act_reg >= JAB_LIM)
          begin
            jab_next   = 1'b1;
            state_next = ST_CUT;
          end
          // starts inside the quiet time are not served
          else if ((quiet_reg >= QUIET_CYC) && (quiet_reg >= drain))
          begin
            // gap starts at the last edge
            gap_next   = quiet_reg;
            state_next = ST_IDLE;
          end
        end
        ST_CUT:
        begin
          // Isolated until the jabbering segment falls quiet
          if (quiet_reg >= QUIET_CYC)
          begin
            gap_next   = quiet_reg;
            state_next = ST_IDLE;
          end
        end
      endcase
    end

    // Registers only
    always_ff @(posedge i_sys_clk)
    begin
      if (i_sys_rst)
      begin
        state_reg <= ST_IDLE;
        dir_reg   <= 1'b0;
        long_reg  <= 1'b0;
        coll_reg  <= 1'b0;
        jab_reg   <= 1'b0;
        quiet_reg <= CNT_ZERO;
        act_reg   <= CNT_ZERO;
        gap_reg   <= GAP_LONG_CYC;
        rx1_reg   <= 1'b0;
        rx2_reg   <= 1'b0;
        tx1_reg   <= 1'b0;
        oe1_reg   <= 1'b0;
        tx2_reg   <= 1'b0;
        oe2_reg   <= 1'b0;
      end
      else
      begin
        state_reg <= state_next;
        dir_reg   <= dir_next;
        long_reg  <= long_next;
        coll_reg  <= coll_next;
        jab_reg   <= jab_next;
        quiet_reg <= quiet_next;
        act_reg   <= act_next;
        gap_reg   <= gap_next;
        rx1_reg   <= rx1_next;
        rx2_reg   <= rx2_next;
        tx1_reg   <= tx1_next;
        oe1_reg   <= oe1_next;
        tx2_reg   <= tx2_next;
        oe2_reg   <= oe2_next;
      end
    end

    // Outputs straight from flops
    assign o_seg1_tx[g]    = tx1_reg;
    assign o_seg1_oe[g]    = oe1_reg;
    assign o_seg2_tx[g]    = tx2_reg;
    assign o_seg2_oe[g]    = oe2_reg;
    assign o_collision[g]  = coll_reg;
    assign o_jabber_cut[g] = jab_reg;

    a_idle_no_drive :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_IDLE) |=> (!oe1_reg && !oe2_reg))
      else $error("Idle line drove a segment");

    a_claim_dir :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_IDLE && (e1 || e2)) |=> (state_reg == ST_CHECK && dir_reg == !$past(e1)))
      else $error("Start edge did not claim its direction");

    a_fwd_side :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_FWD) |=> (dir_reg ? (oe1_reg && !oe2_reg) : (oe2_reg && !oe1_reg)))
      else $error("Forwarding drove the wrong segment");

    a_regen_latency :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_FWD && !dir_reg && !coll_reg && !long_reg && act_reg >= SHORT_FILL)
        |=> (tx2_reg == $past(i_seg1_rx[g], SHORT_TAP_LEN + 1)))
      else $error("Regenerated output is not the delayed input");

    a_postpone_tap :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_FWD && !dir_reg && !coll_reg && long_reg && act_reg >= LONG_FILL)
        |=> (tx2_reg == $past(i_seg1_rx[g], LONG_TAP_LEN + 1)))
      else $error("Postponed output has the wrong delay");

    a_fill_idle :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_FWD && !coll_reg && act_reg < (long_reg ? LONG_FILL : SHORT_FILL))
        |=> (!tx1_reg && !tx2_reg))
      else $error("Output left idle before the delayed start");

    a_gap_select :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_IDLE && (e1 || e2) && gap_reg >= GAP_LONG_CYC) |=> !long_reg)
      else $error("Distant frame was postponed");

    a_hold_dir :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_FWD && quiet_reg < QUIET_CYC) |=> (state_reg != ST_IDLE && $stable(dir_reg)))
      else $error("Direction released before quiet time");

    a_coll_raw :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_FWD && in_edge && quiet_reg < MIN_SPACE_CYC)
        |=> coll_reg ##1 ((!oe1_reg && !oe2_reg) || ((dir_reg ? tx1_reg : tx2_reg) == $past(in_now))))
      else $error("Illegal transition not handled as collision");

    a_check_reject :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_CHECK && in_edge) |=> (state_reg == ST_IDLE))
      else $error("Short start bit was accepted");

    a_jabber_cut :
    assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == ST_FWD && act_reg >= JAB_LIM) |=> (state_reg == ST_CUT && jab_reg) ##1 !oe1_reg && !oe2_reg)
      else $error("Jabbering frame was not cut");
  end

endmodule // bsr_repeater_top
`default_nettype wire
